// ==== flash_id_host.sv ====
`timescale 1ns/1ps
//
// Behaviour
// - Host holds id address pin at high voltage for high-voltage id reads.
// - Host drives code select bits, bit6 low; read with CE, OE low, WE high.
// - Protect verify puts sector address on high bits; data bit0 one if protected.
// - Host applies high voltage only on clear pin for protect operations.
//
module flash_id_host
    import flash_id_pkg::*;
#(
    parameter int HOLD_CYC = STROBE_CYC // Cycles each write strobe and clear pulse lasts
)(
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, high
    input wire logic req_valid, // Start an operation
    input wire op_t req_op, // Operation kind
    input wire logic req_hv, // Use high-voltage id method
    input wire logic [1:0] req_code, // Identifier code to read
    input wire logic [ADDR_W-1:0] req_addr, // Word address or sector address
    input wire logic [DATA_W-1:0] req_wdata, // Write data
    input wire logic req_clear, // Pulse the hardware clear pin
    input wire logic req_unprot, // Hold clear pin at high voltage
    input wire logic [DATA_W-1:0] dq_in, // Data pins from device
    output logic req_ready, // Idle and able to accept
    output logic rsp_valid, // Read data ready, one cycle
    output logic [DATA_W-1:0] rsp_data, // Read data
    output logic rsp_protected, // Sector protected, from protect verify
    output logic rsp_locked, // Secured region factory locked
    output logic rsp_esn, // Address lies in serial-number words
    output logic [SECT_W-1:0] rsp_sector, // Sector decoded from address
    output logic [ADDR_W-1:0] addr_out, // Address pins
    output logic [DATA_W-1:0] dq_out, // Data pins to device
    output logic dq_oe, // High while host drives data pins
    output logic ce_n, // Chip select, low active
    output logic oe_n, // Output drive, low active
    output logic we_n, // Write strobe, low active
    output logic clear_n, // Hardware clear pin, low active
    output logic clear_hv, // Clear pin raised to high voltage
    output logic id_hv // Id address pin raised to high voltage
);
    // Strobe length must fit the phase counter
    if (HOLD_CYC < 1 || HOLD_CYC >= (1 << CNT_W)) begin : g_hold_chk
        $error("HOLD_CYC out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER,
        ST_CLEAR
    } state_t;

    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(ACCESS_CYC - 1);

    logic [SECT_W-1:0] dec_sector;

    state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    op_t op_ff, nxt_op;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] dq_ff, nxt_dq;
    logic dq_oe_ff, nxt_dq_oe;
    logic ce_n_ff, nxt_ce_n;
    logic oe_n_ff, nxt_oe_n;
    logic we_n_ff, nxt_we_n;
    logic clear_n_ff, nxt_clear_n;
    logic clear_hv_ff, nxt_clear_hv;
    logic id_hv_ff, nxt_id_hv;
    logic hv_read_ff, nxt_hv_read;
    logic [1:0] code_ff, nxt_code;
    logic rsp_valid_ff, nxt_rsp_valid;
    logic [DATA_W-1:0] rsp_data_ff, nxt_rsp_data;
    logic rsp_prot_ff, nxt_rsp_prot;
    logic rsp_lock_ff, nxt_rsp_lock;
    logic rsp_esn_ff, nxt_rsp_esn;
    logic [SECT_W-1:0] rsp_sector_ff, nxt_rsp_sector;

    // Build id-read address: code bits low, bit6 low, sector on high bits for protect verify only
    function automatic logic [ADDR_W-1:0] id_addr(input logic [1:0] code,
                                                 input logic [ADDR_W-1:0] sa);
        logic [ADDR_W-1:0] a;
        a = '0;
        if (code == SEL_PROTECT) begin
            a = {sa[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
        end
        a[CODE_BIT6] = 1'b0;
        a[CODE_BIT1] = code[1];
        a[CODE_BIT0] = code[0];
        return a;
    endfunction

    // Word address in the secured region's serial-number words
    function automatic logic in_esn(input logic [ADDR_W-1:0] a);
        return (a >= SECURE_BASE) && (a <= ESN_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////
    sector_decode u_dec (
        .addr(addr_ff),
        .sector(dec_sector),
        .prot_addr()
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer for bus cycles and clear-pin control
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        nxt_dq = dq_ff;
        nxt_dq_oe = dq_oe_ff;
        nxt_ce_n = ce_n_ff;
        nxt_oe_n = oe_n_ff;
        nxt_we_n = we_n_ff;
        nxt_clear_n = clear_n_ff;
        nxt_clear_hv = req_unprot;
        nxt_id_hv = id_hv_ff;
        nxt_hv_read = hv_read_ff;
        nxt_code = code_ff;
        nxt_rsp_valid = 1'b0;
        nxt_rsp_data = rsp_data_ff;
        nxt_rsp_prot = rsp_prot_ff;
        nxt_rsp_lock = rsp_lock_ff;
        nxt_rsp_esn = rsp_esn_ff;
        nxt_rsp_sector = rsp_sector_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_cnt = '0;
                if (req_clear) begin
                    nxt_clear_n = 1'b0;
                    nxt_state = ST_CLEAR;
                end else if (req_valid) begin
                    nxt_op = req_op;
                    nxt_code = req_code;
                    nxt_hv_read = (req_op == OP_READ_ID) && req_hv;
                    nxt_id_hv = (req_op == OP_READ_ID) && req_hv;
                    nxt_addr = (req_op == OP_READ_ID) ? id_addr(req_code, req_addr)
                                                      : req_addr;
                    nxt_dq = req_wdata;
                    nxt_dq_oe = (req_op == OP_WRITE);
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                nxt_ce_n = 1'b0;
                nxt_oe_n = (op_ff == OP_WRITE);
                nxt_we_n = (op_ff != OP_WRITE);
                nxt_state = ST_STROBE;
            end
            ST_STROBE: begin
                nxt_cnt = cnt_ff + CNT_W'(1);
                if (cnt_ff >= ((op_ff == OP_WRITE) ? HOLD_LAST : READ_LAST)) begin
                    nxt_ce_n = 1'b1;
                    nxt_oe_n = 1'b1;
                    nxt_we_n = 1'b1;
                    nxt_cnt = '0;
                    if (op_ff != OP_WRITE) begin
                        nxt_rsp_valid = 1'b1;
                        nxt_rsp_data = dq_in;
                        nxt_rsp_sector = dec_sector;
                        nxt_rsp_esn = in_esn(addr_ff);
                        if (op_ff == OP_READ_ID) begin
                            nxt_rsp_data = {{(DATA_W-8){1'b0}}, dq_in[7:0]};
                            if (code_ff == SEL_PROTECT) begin
                                nxt_rsp_prot = dq_in[PROT_BIT];
                            end
                            if (code_ff == SEL_LOCK) begin
                                nxt_rsp_lock = dq_in[LOCK_BIT];
                            end
                        end
                    end
                    nxt_state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                nxt_dq_oe = 1'b0;
                nxt_id_hv = 1'b0;
                nxt_hv_read = 1'b0;
                nxt_state = ST_IDLE;
            end
            ST_CLEAR: begin
                nxt_cnt = cnt_ff + CNT_W'(1);
                if (cnt_ff >= HOLD_LAST) begin
                    nxt_clear_n = 1'b1;
                    nxt_cnt = '0;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            op_ff <= OP_READ;
            addr_ff <= '0;
            dq_ff <= '0;
            dq_oe_ff <= 1'b0;
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            clear_n_ff <= 1'b1;
            clear_hv_ff <= 1'b0;
            id_hv_ff <= 1'b0;
            hv_read_ff <= 1'b0;
            code_ff <= SEL_MANUF;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= '0;
            rsp_prot_ff <= 1'b0;
            rsp_lock_ff <= 1'b0;
            rsp_esn_ff <= 1'b0;
            rsp_sector_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            op_ff <= nxt_op;
            addr_ff <= nxt_addr;
            dq_ff <= nxt_dq;
            dq_oe_ff <= nxt_dq_oe;
            ce_n_ff <= nxt_ce_n;
            oe_n_ff <= nxt_oe_n;
            we_n_ff <= nxt_we_n;
            clear_n_ff <= nxt_clear_n;
            clear_hv_ff <= nxt_clear_hv;
            id_hv_ff <= nxt_id_hv;
            hv_read_ff <= nxt_hv_read;
            code_ff <= nxt_code;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
            rsp_prot_ff <= nxt_rsp_prot;
            rsp_lock_ff <= nxt_rsp_lock;
            rsp_esn_ff <= nxt_rsp_esn;
            rsp_sector_ff <= nxt_rsp_sector;
        end
    end

    // Idle flag registered alongside state
    logic ready_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= (nxt_state == ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign req_ready = ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign rsp_protected = rsp_prot_ff;
    assign rsp_locked = rsp_lock_ff;
    assign rsp_esn = rsp_esn_ff;
    assign rsp_sector = rsp_sector_ff;
    assign addr_out = addr_ff;
    assign dq_out = dq_ff;
    assign dq_oe = dq_oe_ff;
    assign ce_n = ce_n_ff;
    assign oe_n = oe_n_ff;
    assign we_n = we_n_ff;
    assign clear_n = clear_n_ff;
    assign clear_hv = clear_hv_ff;
    assign id_hv = id_hv_ff;
endmodule

// ==== flash_id_pkg.sv ====
package flash_id_pkg;
    // Address and data widths of the flash bus
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int SECT_W = 6;
    localparam int NUM_SECTORS = 35;
    // Identifier code selects on code_select_bits (bit1, bit0)
    localparam logic [1:0] SEL_MANUF = 2'h0;
    localparam logic [1:0] SEL_DEVICE = 2'h1;
    localparam logic [1:0] SEL_PROTECT = 2'h2;
    localparam logic [1:0] SEL_LOCK = 2'h3;
    // Address bit positions used by the identifier read
    localparam int CODE_BIT0 = 0;
    localparam int CODE_BIT1 = 1;
    localparam int CODE_BIT6 = 6;
    localparam int ID_PIN_BIT = 9;
    localparam int SECT_LSB = 12;
    // Bottom-boot sector decode bit positions
    localparam int BIG_MSB = 19;
    localparam int BIG_LSB = 15;
    localparam int HALF_BIT = 14;
    localparam int PAIR_BIT = 13;
    localparam int FIRST_BIG = 3;
    // Identifier data decode
    localparam int LOCK_BIT = 7;
    localparam logic [7:0] LOCK_LOW_CODE = 8'h03;
    localparam int PROT_BIT = 0;
    // Secured region word range
    localparam logic [ADDR_W-1:0] SECURE_BASE = 20'hf8000;
    localparam logic [ADDR_W-1:0] SECURE_LAST = 20'hf807f;
    localparam logic [ADDR_W-1:0] ESN_LAST = 20'hf8007;
    // Bus timing, in ns, and derived cycle counts at 100 MHz
    localparam int CLK_NS = 10;
    localparam int ACCESS_NS = 70;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_NS = 50;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    // Host operations
    typedef enum logic [1:0] {
        OP_READ_ID,
        OP_WRITE,
        OP_READ
    } op_t;
endpackage

// ==== sector_decode.sv ====
`timescale 1ns/1ps
module sector_decode
    import flash_id_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr, // Word address
    output logic [SECT_W-1:0] sector, // Bottom-boot sector number
    output logic [SECT_W-1:0] prot_addr // Copy of the sector number
);
    // Bottom boot: 16K, 8K, 8K, 32K bytes then 64 Kbyte sectors
    always_comb begin
        prot_addr = '0;
        if (addr[BIG_MSB:BIG_LSB] != '0) begin
            sector = SECT_W'(addr[BIG_MSB:BIG_LSB]) + SECT_W'(FIRST_BIG);
        end else if (addr[HALF_BIT]) begin
            sector = SECT_W'(FIRST_BIG);
        end else if (addr[PAIR_BIT]) begin
            sector = addr[SECT_LSB] ? SECT_W'(2) : SECT_W'(1);
        end else begin
            sector = '0;
        end
        prot_addr = sector;
    end
endmodule

// ==== flash_id_host_props.sv ====
`timescale 1ns/1ps
module flash_id_host_props import flash_id_pkg::*; (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic req_valid, // Request
    input wire op_t req_op, // Kind
    input wire logic req_hv, // Id by high voltage
    input wire logic [1:0] req_code, // Id code
    input wire logic [ADDR_W-1:0] req_addr, // Address
    input wire logic req_clear, // Clear pulse
    input wire logic req_unprot, // Unprotect level
    input wire logic req_ready, // Idle
    input wire logic rsp_valid, // Answer
    input wire logic [DATA_W-1:0] rsp_data, // Answer data
    input wire logic [ADDR_W-1:0] addr_out, // Address pins
    input wire logic ce_n, // Chip select
    input wire logic oe_n, // Output drive
    input wire logic we_n, // Write strobe
    input wire logic clear_n, // Clear pin
    input wire logic dq_oe, // Host drives data pins
    input wire logic clear_hv, // Clear pin high voltage
    input wire logic id_hv // Id pin high voltage
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic take;
    logic [7:0] sa_req;
    // Accepted request and its sector field
    assign take = req_valid && req_ready && !req_clear;
    assign sa_req = req_addr[ADDR_W-1:SECT_LSB];
    AST_READ_PINS: assert property (!oe_n |-> !ce_n && we_n)
        else $error("output drive without select");
    AST_WRITE_PINS: assert property (!we_n |-> !ce_n && oe_n)
        else $error("write strobe with output drive");
    AST_DQ_WRITE: assert property (!we_n |-> dq_oe)
        else $error("data pins not driven during write");
    AST_DQ_READ: assert property (!oe_n |-> !dq_oe)
        else $error("data pins driven during read");
    AST_CODE_SEL: assert property (take && req_op == OP_READ_ID |=>
        !addr_out[CODE_BIT6] && addr_out[CODE_BIT1:CODE_BIT0] == $past(req_code))
        else $error("code select bits wrong");
    AST_SECT_ADDR: assert property (take && req_code == SEL_PROTECT &&
        req_op == OP_READ_ID |=> addr_out[ADDR_W-1:SECT_LSB] == $past(sa_req))
        else $error("sector address wrong");
    AST_HV_HOLD: assert property (take && req_op == OP_READ_ID && req_hv |=> id_hv [*8])
        else $error("id pin voltage dropped");
    AST_ID_UPPER: assert property (take && req_op == OP_READ_ID |->
        ##9 rsp_valid && rsp_data[DATA_W-1:8] == 8'h00)
        else $error("id answer late or wide");
    AST_STROBE_LEN: assert property ($fell(oe_n) |-> (!oe_n && !ce_n) [*7] ##1 oe_n)
        else $error("read strobe length wrong");
    AST_HV_CLEAR: assert property (clear_hv |-> clear_n && !id_hv)
        else $error("high voltage on wrong pin");
    AST_UNPROT: assert property ($rose(req_unprot) |=> clear_hv)
        else $error("clear voltage not raised");
    cover property (take && req_op == OP_READ_ID && req_hv);
    cover property (take && req_op == OP_WRITE && clear_hv);
    cover property ($fell(clear_n));
endmodule

// ==== flash_dev_model.sv ====
`timescale 1ns/1ps
module flash_dev_model import flash_id_pkg::*; #(
    parameter logic [7:0] MANUF = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEVID = 8'ha6, // Arbitrary value
    parameter bit LOCKED = 1'b1 // Factory locked part
)(
    input wire logic [ADDR_W-1:0] addr_out, // Address
    input wire logic [DATA_W-1:0] dq_out, // Host data
    input wire logic ce_n, // Select
    input wire logic oe_n, // Output drive
    input wire logic we_n, // Write strobe
    input wire logic clear_n, // Clear pin
    input wire logic clear_hv, // Clear pin high voltage
    input wire logic id_hv, // Id pin high voltage
    output logic [DATA_W-1:0] dq_in // Device data
);
    logic [DATA_W-1:0] mem [int];
    logic [NUM_SECTORS-1:0] prot = '0;
    logic [1:0] mode = 2'h0;
    logic arm = 1'b0;
    logic wsel = 1'b0;
    // Select latched just after the write strobe falls; both strobes rise together
    always @(negedge we_n) begin
        #1 wsel = !ce_n && clear_n;
    end
    logic [DATA_W-1:0] last = 16'h0000;
    // Bottom-boot sector of a word address
    function automatic logic [SECT_W-1:0] sect_of(logic [ADDR_W-1:0] a);
        if (a[19:15] != 5'h00) return {1'b0, a[19:15]} + 6'h03;
        if (a[14]) return 6'h03;
        return a[13] ? {5'h00, a[12]} + 6'h01 : 6'h00;
    endfunction
    // Read path: id codes, secured region, then array
    function automatic logic [DATA_W-1:0] rd(logic [ADDR_W-1:0] a);
        if (id_hv || mode == 2'h1) begin
            case (a[1:0])
                SEL_MANUF: return {8'h00, MANUF};
                SEL_DEVICE: return {8'h00, DEVID};
                SEL_PROTECT: return {15'h0000, prot[sect_of(a)]};
                default: return {8'h00, LOCKED, LOCK_LOW_CODE[6:0]};
            endcase
        end
        if (mode == 2'h2 && a >= SECURE_BASE && a <= SECURE_LAST) begin
            return {8'h5e, a[7:0]};
        end
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    // Commands at 0x555, protect, program on rising strobe
    always @(posedge we_n) begin
        if (wsel && addr_out == 20'h00555) begin
            arm <= dq_out[7:0] == 8'h60;
            if (!(dq_out[7:0] == 8'h20 && mode == 2'h2)) begin
                mode <= dq_out[7:0] == 8'h90 ? 2'h1 : {dq_out[7:0] == 8'h88, 1'b0};
            end
        end else if (wsel && arm) begin
            prot[sect_of(addr_out)] <= clear_hv;
            arm <= 1'b0;
        end else if (wsel && (!prot[sect_of(addr_out)] || clear_hv)) begin
            mem[addr_out] = dq_out;
        end
    end
    // Clear pulse aborts and maps the array back
    always @(negedge clear_n) begin
        mode <= 2'h0;
        arm <= 1'b0;
    end
    // Data pins; released pins show the inverse of the last value
    always @(addr_out, ce_n, oe_n, we_n, id_hv, mode, prot, clear_n) begin
        if (!ce_n && !oe_n && we_n && clear_n) begin
            dq_in = rd(addr_out);
            last = dq_in;
        end else begin
            dq_in = ~last;
        end
    end
endmodule

// ==== flash_id_host_tb.sv ====
`timescale 1ns/1ps
module flash_id_host_tb import flash_id_pkg::*;;
    logic clk = 0, rst = 1, req_valid = 0, req_hv = 0, req_clear = 0, req_unprot = 0;
    op_t req_op = OP_READ;
    logic [1:0] req_code = 2'h0;
    logic [ADDR_W-1:0] req_addr = '0, addr_out, a, b;
    logic [DATA_W-1:0] req_wdata = '0, dq_in, rsp_data, dq_out, got;
    logic req_ready, rsp_valid, rsp_protected, rsp_locked, rsp_esn, dq_oe;
    logic ce_n, oe_n, we_n, clear_n, clear_hv, id_hv;
    logic [SECT_W-1:0] rsp_sector;
    logic [7:0] ids [4] = '{8'h5a, 8'ha6, 8'h00, LOCK_LOW_CODE | 8'h80};
    logic [ADDR_W-1:0] corner [6] = '{20'h01fff, 20'h02000, 20'h03000, 20'h04000,
        20'hf8007, 20'hf8008};
    int failures = 0, n_compared = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    flash_id_host i_dut (.clk, .rst, .req_valid, .req_op, .req_hv, .req_code, .req_addr,
        .req_wdata, .req_clear, .req_unprot, .dq_in, .req_ready, .rsp_valid, .rsp_data,
        .rsp_protected, .rsp_locked, .rsp_esn, .rsp_sector, .addr_out, .dq_out, .dq_oe,
        .ce_n, .oe_n, .we_n, .clear_n, .clear_hv, .id_hv);
    flash_dev_model i_flash (.addr_out, .dq_out, .ce_n, .oe_n, .we_n, .clear_n,
        .clear_hv, .id_hv, .dq_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] seen);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One request, held until taken; reads wait for the answer
    task automatic run(op_t op, logic hv, logic [1:0] code, logic [ADDR_W-1:0] ad,
        logic [DATA_W-1:0] wd);
        req_valid <= 1'b1;
        req_op <= op;
        req_hv <= hv;
        req_code <= code;
        req_addr <= ad;
        req_wdata <= wd;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge clk); while (op == OP_WRITE ? req_ready !== 1'b1 : rsp_valid !== 1'b1);
        got = rsp_data;
    endtask
    task automatic summarize();
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'h31bfcc27));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            run(OP_READ_ID, 1'b1, 2'(k), 20'h00000, 16'h0000);
            chk("id code", {8'h00, ids[k]}, got);
        end
        chk("lock flag", 16'h0001, {15'h0000, rsp_locked});
        run(OP_WRITE, 1'b0, 2'h0, 20'h00555, 16'h0090);
        run(OP_READ_ID, 1'b0, SEL_DEVICE, 20'h00000, 16'h0000);
        chk("in-system id", {8'h00, ids[1]}, got);
        run(OP_WRITE, 1'b0, 2'h0, 20'h00555, 16'h00f0);
        // Protect a random sector, then program it locked and unlocked
        a = {5'($urandom_range(31, 1)), 15'($urandom)};
        req_unprot <= 1'b1;
        run(OP_WRITE, 1'b0, 2'h0, 20'h00555, 16'h0060);
        run(OP_WRITE, 1'b0, 2'h0, a, 16'h0000);
        req_unprot <= 1'b0;
        run(OP_READ_ID, 1'b1, SEL_PROTECT, a, 16'h0000);
        chk("protect verify", 16'h0001, got);
        chk("protected flag", 16'h0001, {15'h0000, rsp_protected});
        run(OP_WRITE, 1'b0, 2'h0, a, 16'h1234);
        run(OP_READ, 1'b0, 2'h0, a, 16'h0000);
        chk("refused program", 16'hffff, got);
        req_unprot <= 1'b1;
        run(OP_WRITE, 1'b0, 2'h0, a, 16'h1234);
        run(OP_READ, 1'b0, 2'h0, a, 16'h0000);
        chk("unprotected program", 16'h1234, got);
        req_unprot <= 1'b0;
        run(OP_WRITE, 1'b0, 2'h0, a, 16'h0000);
        run(OP_READ, 1'b0, 2'h0, a, 16'h0000);
        chk("protection back", 16'h1234, got);
        // Sector decode and serial-number flag over corners and random words
        for (int k = 0; k < 26; k++) begin
            b = k < 6 ? corner[k] : 20'($urandom);
            run(OP_READ, 1'b0, 2'h0, b, 16'h0000);
            chk("array data", b == a ? 16'h1234 : 16'hffff, got);
            chk("sector", {10'h000, i_flash.sect_of(b)}, {10'h000, rsp_sector});
            chk("esn flag", {15'h0000, b >= SECURE_BASE && b <= ESN_LAST}, {15'h0000, rsp_esn});
        end
        // Secured region mapped in, then unmapped by a clear pulse
        run(OP_WRITE, 1'b0, 2'h0, 20'h00555, 16'h0088);
        run(OP_READ, 1'b0, 2'h0, 20'hf8040, 16'h0000);
        chk("secured word", 16'h5e40, got);
        run(OP_WRITE, 1'b0, 2'h0, 20'h00555, 16'h0020);
        run(OP_READ, 1'b0, 2'h0, 20'hf8040, 16'h0000);
        chk("bypass refused", 16'h5e40, got);
        req_clear <= 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_clear <= 1'b0;
        run(OP_READ, 1'b0, 2'h0, 20'hf8040, 16'h0000);
        chk("array after clear", 16'hffff, got);
        summarize();
    end
endmodule
bind flash_id_host flash_id_host_props i_props (.clk, .rst, .req_valid, .req_op, .req_hv,
    .req_code, .req_addr, .req_clear, .req_unprot, .req_ready, .rsp_valid, .rsp_data,
    .addr_out, .ce_n, .oe_n, .we_n, .clear_n, .dq_oe, .clear_hv, .id_hv);
